// >>> bench/cos_contact_sense.sv
`timescale 1ns/1ps
`default_nettype none

module cos_contact_sense (
    input  wire logic       mclk,
    input  wire logic [5:0] contact_closed,
    output var  logic [5:0] sensed
);
    // ----------------------------------------
    // Customer equipment reading the contacts
    // ----------------------------------------
    // Read mid-cycle, clear of the edge where the relay drivers switch
    always @(negedge mclk) begin
        sensed <= contact_closed;
    end
endmodule

`default_nettype wire

// >>> bench/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "cos_cfg.svh"

module tb_top;
    logic              mclk;
    logic              reset;
    logic              hsel;
    logic [31:0]       haddr;
    logic [1:0]        htrans;
    logic              hwrite;
    logic [2:0]        hsize;
    logic [31:0]       hwdata;
    logic [31:0]       hrdata;
    logic              hreadyout;
    logic              hresp;
    cos_pkg::cos_src_s src;
    logic [5:0]        contact_closed;
    logic [5:0]        sensed;
    int                miscompares;
    int                compares;

    cos_contact_output_selector cos_contact_output_selector_inst (
        .mclk(mclk), .reset(reset), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .src(src),
        .contact_closed(contact_closed)
    );

    cos_contact_sense cos_contact_sense_inst (
        .mclk(mclk), .contact_closed(contact_closed), .sensed(sensed)
    );

    // ----------------------------------------
    // Clock and reporting
    // ----------------------------------------
    always #50 mclk = ~mclk;

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            miscompares++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic wrap_up;
        if (miscompares == 0 && compares > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // ----------------------------------------
    // Bus master and reference model
    // ----------------------------------------
    // Never assumes zero wait states, a stalled slave ends the run
    task automatic bus_wait;
        int n;
        n = 0;
        do begin
            @(posedge mclk);
            n++;
        end while (hreadyout !== 1'b1 && n < 20);
        if (hreadyout !== 1'b1) begin
            miscompares++;
            $display("Error bus ready expected 1 seen %b", hreadyout);
            wrap_up();
        end
    endtask

    task automatic ahb(input logic wr, input logic [31:0] addr, input logic [31:0] wdata,
                       output logic [31:0] rdata);
        htrans <= 2'b10;
        haddr  <= addr;
        hwrite <= wr;
        bus_wait();
        htrans <= 2'b00;
        hwdata <= wdata;
        bus_wait();
        rdata = hrdata;
    endtask

    task automatic look;
        @(negedge mclk);
        #1;
    endtask

    function automatic logic cond_of(input logic [3:0] code, input cos_pkg::cos_src_s s);
        case (code)
            4'h2: return s.operating;
            4'h3: return s.dio_mode;
            4'h4: return s.stop_class_alarm;
            4'h5: return s.continue_class_alarm;
            4'h6: return s.stop_class_alarm | s.continue_class_alarm;
            4'h7: return s.maint_pending;
            4'h8: return s.temp_ready_channel_one;
            4'h9: return s.temp_ready_channel_two;
            4'ha: return s.temp_out;
            default: return 1'b0;
        endcase
    endfunction

    // Outputs 1-3 fixed sources, 4-6 through their selected code
    function automatic logic [5:0] model_out(input logic [2:0] ff, input logic [11:0] cd,
                                             input logic [2:0] fs, input cos_pkg::cos_src_s s);
        model_out[0] = s.operating ^ ff[0];
        model_out[1] = s.stop_class_alarm ^ ff[1];
        model_out[2] = s.continue_class_alarm ^ ff[2];
        for (int i = 0; i < 3; i++) begin
            model_out[3 + i] = cond_of(cd[4 * i +: 4], s) ^ fs[i];
        end
    endfunction

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    // Reset levels and defaults, used at start and again at the end
    task automatic test_defaults;
        logic [31:0] rd;
        reset <= 1'b1;
        src   <= '0;
        repeat (4) @(posedge mclk);
        look();
        check("contacts in reset", {26'h0, sensed}, 32'h0);
        @(posedge mclk);
        reset <= 1'b0;
        @(posedge mclk);
        look();
        check("released", {26'h0, sensed}, 32'h6);
        @(posedge mclk);
        ahb(1'b0, `COS_OFS_FIXED_FORM, 32'h0, rd);
        check("fixed form default", rd, 32'h6);
        for (int i = 1; i < 4; i++) begin
            ahb(1'b0, 32'(4 * i), 32'h0, rd);
            check("selector default", rd, 32'h1);
        end
    endtask

    // Every code and form on 4-6, every fixed form, each source alone
    task automatic test_routing;
        logic [31:0]       rd;
        logic [3:0]        code;
        logic              fb;
        logic [2:0]        ff;
        logic [11:0]       cd;
        cos_pkg::cos_src_s s;
        cos_pkg::cos_src_s s_old;
        logic [31:0]       got;
        logic [31:0]       want;
        s_old = '0;
        want  = '0;
        for (int c = 0; c < 12; c++) begin
            for (int f = 0; f < 2; f++) begin
                code = 4'(c);
                fb   = f[0];
                ff   = code[2:0] ^ {3{fb}};
                cd   = {4'hb - code, code, code};
                ahb(1'b1, `COS_OFS_FIXED_FORM, {29'h0, ff}, rd);
                ahb(1'b1, `COS_OFS_SEL4, 32'hffff_fe00 | {23'h0, fb, 4'h0, code}, rd);
                ahb(1'b1, `COS_OFS_SEL5, {23'h0, ~fb, 4'h0, code}, rd);
                ahb(1'b1, `COS_OFS_SEL6, {23'h0, fb, 4'h0, cd[11:8]}, rd);
                ahb(1'b0, `COS_OFS_SEL4, 32'h0, rd);
                check("selector readback", rd, {23'h0, fb, 4'h0, code});
                for (int b = 0; b < 9; b++) begin
                    s = (b == 8) ? cos_pkg::cos_src_s'(8'h00) : cos_pkg::cos_src_s'(8'h01 << b);
                    src <= s;
                    look();
                    check("contacts before edge", {26'h0, sensed},
                          {26'h0, model_out(ff, cd, {fb, ~fb, fb}, s_old)});
                    @(posedge mclk);
                    look();
                    got  = {26'h0, sensed};
                    want = {26'h0, model_out(ff, cd, {fb, ~fb, fb}, s)};
                    check("routed", got, want);
                    check("routed sel", got >> 3, want >> 3);
                    @(posedge mclk);
                    s_old = s;
                end
                ahb(1'b0, `COS_OFS_STATUS, 32'h0, rd);
                check("status", rd, {10'h0, want[5:0], 8'h0, s_old});
            end
        end
    endtask

    // Read-only and unmapped places leave the configuration alone
    task automatic test_bus_edges;
        logic [31:0] rd;
        ahb(1'b1, `COS_OFS_STATUS, 32'hffff_ffff, rd);
        ahb(1'b1, 32'h0000_0014, 32'hffff_ffff, rd);
        ahb(1'b1, 32'h1000_0000, 32'h0000_0007, rd);
        ahb(1'b0, 32'h0000_0014, 32'h0, rd);
        check("unmapped read", rd, 32'h0);
        ahb(1'b0, `COS_OFS_FIXED_FORM, 32'h0, rd);
        // Last routing pass wrote code 11 with break: 3'b011 inverted
        check("fixed form kept", rd, 32'h4);
        check("response okay", {31'h0, hresp}, 32'h0);
    endtask

    initial begin
        mclk        = 1'b0;
        reset       = 1'b1;
        hsel        = 1'b1;
        haddr       = 32'h0;
        htrans      = 2'b00;
        hwrite      = 1'b0;
        hsize       = 3'h2;
        hwdata      = 32'h0;
        src         = '0;
        miscompares = 0;
        compares    = 0;
        test_defaults();
        test_routing();
        test_bus_edges();
        test_defaults();
        wrap_up();
    end
endmodule

`default_nettype wire

// >>> core/cos_contact_output_selector.sv
// Functional notes
// - Six independent contact outputs, each configured separately.
// - Outputs 1-3 are continuous levels; only their contact form is set.
// - Output 1 shows operating state; form defaults to make.
// - Output 2 shows stop-class alarm; form defaults to break.
// - Output 3 shows continue-class alarm; form defaults to break.
// - Make form closes on true condition; break form inverts it.
// - Outputs 4-6 each have a source selector and a contact form.
// - Outputs 4-6 reset to source off with make form.
// - Code four routes the stop-class alarm.
// - Code six routes general alarm, any alarm active.
// - Code seven routes the maintenance reminder status.
// - Codes eight and nine route channel one and two temperature ready.
`timescale 1ns/1ps
`default_nettype none
`include "cos_cfg.svh"

module cos_contact_output_selector (
    input  wire logic             mclk,
    input  wire logic             reset,
    input  wire logic             hsel,
    input  wire logic [31:0]      haddr,
    input  wire logic [1:0]       htrans,
    input  wire logic             hwrite,
    input  wire logic [2:0]       hsize,
    input  wire logic [31:0]      hwdata,
    input  wire logic             hready,
    output logic      [31:0]      hrdata,
    output logic                  hreadyout,
    output logic                  hresp,
    input  wire cos_pkg::cos_src_s src,
    output logic      [5:0]       contact_closed
);

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    // Condition picked by a source code; unknown codes act as off
    function automatic logic pick_src(input logic [3:0] code,
                                      input cos_pkg::cos_src_s s);
        case (code)
            cos_pkg::COS_SRC_RUN:      pick_src = s.operating;
            cos_pkg::COS_SRC_DIO:      pick_src = s.dio_mode;
            cos_pkg::COS_SRC_STOP:     pick_src = s.stop_class_alarm;
            cos_pkg::COS_SRC_CONT:     pick_src = s.continue_class_alarm;
            cos_pkg::COS_SRC_ALARM:    pick_src = s.stop_class_alarm
                                                | s.continue_class_alarm;
            cos_pkg::COS_SRC_MAINT:    pick_src = s.maint_pending;
            cos_pkg::COS_SRC_TEMP_ONE: pick_src = s.temp_ready_channel_one;
            cos_pkg::COS_SRC_TEMP_TWO: pick_src = s.temp_ready_channel_two;
            cos_pkg::COS_SRC_TEMP_OUT: pick_src = s.temp_out;
            default:                   pick_src = 1'b0;
        endcase
    endfunction

    // Break form inverts the condition
    function automatic logic apply_form(input logic cond, input logic form);
        apply_form = cond ^ form;
    endfunction

    // Read value of one register address
    function automatic logic [31:0] reg_word(input logic [31:0] a,
                                             input logic [2:0]  ff,
                                             input logic [11:0] cd,
                                             input logic [2:0]  fs,
                                             input cos_pkg::cos_src_s s,
                                             input logic [5:0]  c);
        reg_word = 32'h0000_0000;
        case (a)
            `COS_OFS_FIXED_FORM: reg_word[2:0] = ff;
            `COS_OFS_SEL4: begin
                reg_word[`COS_SEL_CODE_LSB +: 4] = cd[3:0];
                reg_word[`COS_SEL_FORM_BIT]      = fs[0];
            end
            `COS_OFS_SEL5: begin
                reg_word[`COS_SEL_CODE_LSB +: 4] = cd[7:4];
                reg_word[`COS_SEL_FORM_BIT]      = fs[1];
            end
            `COS_OFS_SEL6: begin
                reg_word[`COS_SEL_CODE_LSB +: 4] = cd[11:8];
                reg_word[`COS_SEL_FORM_BIT]      = fs[2];
            end
            `COS_OFS_STATUS: begin
                reg_word[`COS_STAT_SRC_LSB +: 8] = s;
                reg_word[`COS_STAT_OUT_LSB +: 6] = c;
            end
            default: reg_word = 32'h0000_0000;
        endcase
    endfunction

    // ----------------------------------------
    // Bus slave state
    // ----------------------------------------
    logic [31:0] wr_addr_reg;
    logic [31:0] wr_addr_next;
    logic        wr_pend_reg;
    logic        wr_pend_next;
    logic [31:0] hrdata_reg;
    logic [31:0] hrdata_next;
    logic        take;
    logic [2:0]  fixed_form_reg;
    logic [2:0]  fixed_form_next;
    logic [11:0] code_reg;
    logic [11:0] code_next;
    logic [2:0]  sel_form_reg;
    logic [2:0]  sel_form_next;
    logic [5:0]  contact_reg;
    logic [5:0]  contact_next;

    // Zero wait states; read data is fetched at the address phase
    assign take = hsel & hready & htrans[1];

    // Address capture and read data, with forwarding of a write
    // still in its data phase so a read straight after sees it
    always_comb begin
        logic [2:0]  ff;
        logic [11:0] cd;
        logic [2:0]  fs;
        ff = fixed_form_reg;
        cd = code_reg;
        fs = sel_form_reg;
        if (wr_pend_reg) begin
            ff = fixed_form_next;
            cd = code_next;
            fs = sel_form_next;
        end
        wr_pend_next = take & hwrite;
        wr_addr_next = take ? haddr : wr_addr_reg;
        hrdata_next  = hrdata_reg;
        if (take && !hwrite) begin
            hrdata_next = reg_word(haddr, ff, cd, fs, src, contact_reg);
        end
    end

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            wr_addr_reg <= 32'h0000_0000;
            wr_pend_reg <= 1'b0;
            hrdata_reg  <= 32'h0000_0000;
        end else begin
            wr_addr_reg <= wr_addr_next;
            wr_pend_reg <= wr_pend_next;
            hrdata_reg  <= hrdata_next;
        end
    end

    // Always ready and OKAY; constants kept in flops
    logic hreadyout_reg;
    logic hresp_reg;
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            hreadyout_reg <= 1'b1;
            hresp_reg     <= 1'b0;
        end else begin
            hreadyout_reg <= 1'b1;
            hresp_reg     <= 1'b0;
        end
    end

    // ----------------------------------------
    // Configuration registers
    // ----------------------------------------

    // Write in data phase; unmapped or status writes are dropped
    always_comb begin
        fixed_form_next = fixed_form_reg;
        code_next       = code_reg;
        sel_form_next   = sel_form_reg;
        if (wr_pend_reg) begin
            case (wr_addr_reg)
                `COS_OFS_FIXED_FORM: fixed_form_next = hwdata[2:0];
                `COS_OFS_SEL4: begin
                    code_next[3:0]   = hwdata[`COS_SEL_CODE_LSB +: 4];
                    sel_form_next[0] = hwdata[`COS_SEL_FORM_BIT];
                end
                `COS_OFS_SEL5: begin
                    code_next[7:4]   = hwdata[`COS_SEL_CODE_LSB +: 4];
                    sel_form_next[1] = hwdata[`COS_SEL_FORM_BIT];
                end
                `COS_OFS_SEL6: begin
                    code_next[11:8]  = hwdata[`COS_SEL_CODE_LSB +: 4];
                    sel_form_next[2] = hwdata[`COS_SEL_FORM_BIT];
                end
                default: fixed_form_next = fixed_form_reg;
            endcase
        end
    end

    // Defaults: out1 make, out2/out3 break, out4-6 off and make
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            fixed_form_reg <= `COS_RST_FIXED_FORM;
            code_reg       <= {3{`COS_RST_SEL_CODE}};
            sel_form_reg   <= {3{`COS_RST_SEL_FORM}};
        end else begin
            fixed_form_reg <= fixed_form_next;
            code_reg       <= code_next;
            sel_form_reg   <= sel_form_next;
        end
    end

    // ----------------------------------------
    // Contact drivers
    // ----------------------------------------

    // Registered so a decode change never glitches a relay driver
    always_comb begin
        contact_next[0] = apply_form(src.operating, fixed_form_reg[0]);
        contact_next[1] = apply_form(src.stop_class_alarm,
                                     fixed_form_reg[1]);
        contact_next[2] = apply_form(src.continue_class_alarm,
                                     fixed_form_reg[2]);
        for (int j = 0; j < 3; j++) begin
            contact_next[3 + j] = apply_form(pick_src(code_reg[4*j +: 4], src),
                                             sel_form_reg[j]);
        end
    end

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            contact_reg <= 6'h00;
        end else begin
            contact_reg <= contact_next;
        end
    end

    assign contact_closed = contact_reg;
    assign hrdata         = hrdata_reg;
    assign hreadyout      = hreadyout_reg;
    assign hresp          = hresp_reg;

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (reset);

    // First edge after release still shows the reset level, so skip it
    a_out1_run: assert property (
        !$past(reset) |->
        contact_closed[0] == ($past(src.operating) ^ $past(fixed_form_reg[0]))
    ) else $error("output 1 does not follow operating state");

    a_out2_stop: assert property (
        !$past(reset) |->
        contact_closed[1] == ($past(src.stop_class_alarm) ^ $past(fixed_form_reg[1]))
    ) else $error("output 2 does not follow stop alarm");

    a_out3_cont: assert property (
        !$past(reset) |->
        contact_closed[2] == ($past(src.continue_class_alarm)
                              ^ $past(fixed_form_reg[2]))
    ) else $error("output 3 does not follow continue alarm");

    a_reset_defaults: assert property (
        $fell(reset) |-> fixed_form_reg == 3'h6 && code_reg == 12'h111
                         && sel_form_reg == 3'h0
    ) else $error("wrong configuration after reset");

    a_sel_stop: assert property (
        code_reg[3:0] == 4'h4 ##1 $stable(code_reg[3:0])
        |-> contact_closed[3] == ($past(src.stop_class_alarm) ^ $past(sel_form_reg[0]))
    ) else $error("code 4 does not route stop alarm");

    a_sel_cont: assert property (
        code_reg[7:4] == 4'h5 ##1 $stable(code_reg[7:4])
        |-> contact_closed[4] == ($past(src.continue_class_alarm)
                                  ^ $past(sel_form_reg[1]))
    ) else $error("code 5 does not route continue alarm");

    a_sel_alarm: assert property (
        code_reg[11:8] == 4'h6 && (src.stop_class_alarm || src.continue_class_alarm)
        |=> contact_closed[5] == !$past(sel_form_reg[2])
    ) else $error("code 6 does not show any alarm");

    a_sel_maint: assert property (
        code_reg[3:0] == 4'h7 && src.maint_pending && !sel_form_reg[0]
        |=> contact_closed[3]
    ) else $error("code 7 make form not closed on reminder");

    a_sel_temp: assert property (
        code_reg[3:0] == 4'h8 || code_reg[7:4] == 4'h9
        |=> ($past(code_reg[3:0]) != 4'h8
             || contact_closed[3] == ($past(src.temp_ready_channel_one)
                                      ^ $past(sel_form_reg[0])))
            && ($past(code_reg[7:4]) != 4'h9
             || contact_closed[4] == ($past(src.temp_ready_channel_two)
                                      ^ $past(sel_form_reg[1])))
    ) else $error("codes 8/9 do not route temperature ready");

    a_off_form: assert property (
        code_reg[11:8] == 4'h1 |=> contact_closed[5] == $past(sel_form_reg[2])
    ) else $error("off source not at rest level");

    a_hold_stable: assert property (
        !$past(reset) && $stable(src) && $stable(code_reg) && $stable(sel_form_reg)
        && $stable(fixed_form_reg) |=> $stable(contact_closed)
    ) else $error("outputs change with steady inputs");

    c_alarm_break: cover property (
        sel_form_reg[2] && code_reg[11:8] == 4'h6 && src.stop_class_alarm ##1 !contact_closed[5]
    );
    c_write_sel: cover property (wr_pend_reg && wr_addr_reg == `COS_OFS_SEL4);
    c_read_status: cover property (take && !hwrite && haddr == `COS_OFS_STATUS);

endmodule

`default_nettype wire

// >>> inc/cos_cfg.svh
`ifndef COS_CFG_SVH
`define COS_CFG_SVH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define COS_OFS_FIXED_FORM  32'h0000_0000
`define COS_OFS_SEL4        32'h0000_0004
`define COS_OFS_SEL5        32'h0000_0008
`define COS_OFS_SEL6        32'h0000_000c
`define COS_OFS_STATUS      32'h0000_0010

// ----------------------------------------
// Field positions
// ----------------------------------------
`define COS_SEL_CODE_LSB    0
`define COS_SEL_FORM_BIT    8
`define COS_STAT_SRC_LSB    0
`define COS_STAT_OUT_LSB    16

// ----------------------------------------
// Reset values
// ----------------------------------------
`define COS_RST_FIXED_FORM  3'h6
`define COS_RST_SEL_CODE    4'h1
`define COS_RST_SEL_FORM    1'h0

`endif

// >>> inc/cos_pkg.sv
`default_nettype none

package cos_pkg;

    // Contact form: make closes on true, break opens on true
    typedef enum logic {
        COS_FORM_MAKE  = 1'b0,
        COS_FORM_BREAK = 1'b1
    } cos_form_e;

    // Source codes for selectable outputs
    typedef enum logic [3:0] {
        COS_SRC_OFF      = 4'h1,
        COS_SRC_RUN      = 4'h2,
        COS_SRC_DIO      = 4'h3,
        COS_SRC_STOP     = 4'h4,
        COS_SRC_CONT     = 4'h5,
        COS_SRC_ALARM    = 4'h6,
        COS_SRC_MAINT    = 4'h7,
        COS_SRC_TEMP_ONE = 4'h8,
        COS_SRC_TEMP_TWO = 4'h9,
        COS_SRC_TEMP_OUT = 4'ha
    } cos_src_code_e;

    // Internal equipment state feeding the contacts
    typedef struct packed {
        logic operating;
        logic stop_class_alarm;
        logic continue_class_alarm;
        logic maint_pending;
        logic dio_mode;
        logic temp_ready_channel_one;
        logic temp_ready_channel_two;
        logic temp_out;
    } cos_src_s;

endpackage

`default_nettype wire
